// ===== sipp_defs.svh
// Offsets, field positions, reset values and encodings of the strobed input port pair.
`ifndef SIPP_DEFS_SVH
`define SIPP_DEFS_SVH
`define SIPP_OFF_DATA_A   2'h0
`define SIPP_OFF_DATA_B   2'h1
`define SIPP_OFF_THIRD    2'h2
`define SIPP_OFF_MODE     2'h3
`define SIPP_MODE_RST     8'h9b
`define SIPP_THIRD_RST    8'h00
`define SIPP_DATA_RST     8'h00
`define SIPP_BIT_MODEDEF  7
`define SIPP_BIT_A_UPIN   3
`define SIPP_BIT_A_IN     4
`define SIPP_BIT_B_MODE   2
`define SIPP_BIT_B_IN     1
`define SIPP_A_MODE1      2'h1
`define SIPP_ST_A_FULL    5
`define SIPP_ST_A_IEN     4
`define SIPP_ST_A_IRQ     3
`define SIPP_ST_B_IEN     2
`define SIPP_ST_B_FULL    1
`define SIPP_ST_B_IRQ     0
`define SIPP_BUF_DEPTH    2
`endif

// ===== sipp_pkg.sv
// Types shared by the strobed input port pair.
`default_nettype none
package sipp_pkg;
    typedef logic [7:0] sipp_byte_t;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [1:0] addr;
        sipp_byte_t data;
    } sipp_req_s;
    typedef struct packed {
        logic       strobe_n;
        sipp_byte_t pins;
    } sipp_link_s;
endpackage : sipp_pkg
`default_nettype wire

// ===== sipp_top.sv
// Strobed input port pair with its two-entry capture buffers.
`timescale 1ns/1ps
`default_nettype none
`include "sipp_defs.svh"

// ==========================================
// Two-entry capture buffer
module sipp_fifo #(
    parameter int W = 8,
    parameter int D = `SIPP_BUF_DEPTH
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic         ce,
    input  wire logic         flush,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    logic [W-1:0]  mem_r [D];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_r != CW'(D));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk)
    begin
        if (srst || (ce && flush))
        begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end
        else if (ce)
        begin
            if (push)
            begin
                wp_r <= (wp_r == PW'(D - 1)) ? '0 : wp_r + 1'b1;
            end
            if (pop)
            begin
                rp_r <= (rp_r == PW'(D - 1)) ? '0 : rp_r + 1'b1;
            end
            cnt_r <= cnt_r + CW'(push) - CW'(pop);
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (ce && push)
        begin
            mem_r[wp_r] <= in_data;
        end
    end
endmodule : sipp_fifo

// ==========================================
// Port pair top
module sipp_top (
    input  wire logic                sys_clk,
    input  wire logic                srst,
    input  wire logic                ce,
    input  wire sipp_pkg::sipp_req_s req,
    output logic [7:0]               rd_data_r,
    input  wire sipp_pkg::sipp_link_s link_a,
    input  wire sipp_pkg::sipp_link_s link_b,
    output logic                     group_a_input_full_r,
    output logic                     group_b_input_full_r,
    output logic                     group_a_irq_request_r,
    output logic                     group_b_irq_request_r,
    output logic                     group_a_space_r,
    output logic                     group_b_space_r,
    input  wire logic [1:0]          third_port_hi_i,
    output logic [1:0]               third_port_hi_o_r,
    output logic                     third_port_hi_oe_r
);
    import sipp_pkg::*;

    sipp_byte_t mode_r;
    sipp_byte_t third_r;
    logic       strb_a_r;
    logic       strb_b_r;
    logic       a_strb;
    logic       b_strb;
    logic       mode_wr;
    logic       bsr_wr;
    logic       fall_a;
    logic       fall_b;
    logic       ibf_a;
    logic       ibf_b;
    logic       rdy_a;
    logic       rdy_b;
    logic       pop_a;
    logic       pop_b;
    logic       inte_a;
    logic       inte_b;
    sipp_byte_t head_a;
    sipp_byte_t head_b;
    sipp_byte_t status;
    sipp_byte_t sel_mask;

    // ==========================================
    // Mode decode
    assign a_strb = (mode_r[6:5] == `SIPP_A_MODE1) && mode_r[`SIPP_BIT_A_IN];
    assign b_strb = mode_r[`SIPP_BIT_B_MODE] && mode_r[`SIPP_BIT_B_IN];
    assign mode_wr = req.wr && (req.addr == `SIPP_OFF_MODE)
                     && req.data[`SIPP_BIT_MODEDEF];
    assign bsr_wr = req.wr && (req.addr == `SIPP_OFF_MODE)
                    && !req.data[`SIPP_BIT_MODEDEF];
    assign sel_mask = 8'h01 << req.data[3:1];
    assign inte_a = third_r[`SIPP_ST_A_IEN];
    assign inte_b = third_r[`SIPP_ST_B_IEN];

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            mode_r <= `SIPP_MODE_RST;
        end
        else if (ce && mode_wr)
        begin
            mode_r <= req.data;
        end
    end

    // Mode definition clears the set/reset latch, so both enables start off.
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            third_r <= `SIPP_THIRD_RST;
        end
        else if (ce && mode_wr)
        begin
            third_r <= `SIPP_THIRD_RST;
        end
        else if (ce && bsr_wr)
        begin
            third_r <= req.data[0] ? (third_r | sel_mask)
                                   : (third_r & ~sel_mask);
        end
    end

    // ==========================================
    // Strobe edges and capture
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            strb_a_r <= 1'b1;
            strb_b_r <= 1'b1;
        end
        else if (ce)
        begin
            strb_a_r <= link_a.strobe_n;
            strb_b_r <= link_b.strobe_n;
        end
    end

    assign fall_a = a_strb && strb_a_r && !link_a.strobe_n;
    assign fall_b = b_strb && strb_b_r && !link_b.strobe_n;
    assign pop_a = req.rd && (req.addr == `SIPP_OFF_DATA_A) && a_strb;
    assign pop_b = req.rd && (req.addr == `SIPP_OFF_DATA_B) && b_strb;

    sipp_fifo #(.W(8), .D(`SIPP_BUF_DEPTH)) u_buf_a (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .ce        (ce),
        .flush     (mode_wr),
        .in_valid  (fall_a),
        .in_data   (link_a.pins),
        .in_ready  (rdy_a),
        .out_valid (ibf_a),
        .out_data  (head_a),
        .out_ready (pop_a)
    );

    sipp_fifo #(.W(8), .D(`SIPP_BUF_DEPTH)) u_buf_b (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .ce        (ce),
        .flush     (mode_wr),
        .in_valid  (fall_b),
        .in_data   (link_b.pins),
        .in_ready  (rdy_b),
        .out_valid (ibf_b),
        .out_data  (head_b),
        .out_ready (pop_b)
    );

    // ==========================================
    // Status byte and register reads
    always_comb
    begin
        status = third_r;
        if (mode_r[`SIPP_BIT_A_UPIN])
        begin
            status[7:6] = third_port_hi_i;
        end
        if (a_strb)
        begin
            status[`SIPP_ST_A_FULL] = ibf_a;
            status[`SIPP_ST_A_IEN]  = inte_a;
            status[`SIPP_ST_A_IRQ]  = inte_a && ibf_a;
        end
        if (b_strb)
        begin
            status[`SIPP_ST_B_IEN]  = inte_b;
            status[`SIPP_ST_B_FULL] = ibf_b;
            status[`SIPP_ST_B_IRQ]  = inte_b && ibf_b;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rd_data_r <= `SIPP_DATA_RST;
        end
        else if (ce && req.rd)
        begin
            case (req.addr)
                `SIPP_OFF_DATA_A: rd_data_r <= head_a;
                `SIPP_OFF_DATA_B: rd_data_r <= head_b;
                `SIPP_OFF_THIRD:  rd_data_r <= status;
                `SIPP_OFF_MODE:   rd_data_r <= mode_r;
                default:          rd_data_r <= `SIPP_DATA_RST;
            endcase
        end
    end

    // ==========================================
    // Handshake and spare pins
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            group_a_input_full_r  <= 1'b0;
            group_b_input_full_r  <= 1'b0;
            group_a_irq_request_r <= 1'b0;
            group_b_irq_request_r <= 1'b0;
            group_a_space_r       <= 1'b0;
            group_b_space_r       <= 1'b0;
        end
        else if (ce)
        begin
            group_a_input_full_r  <= a_strb && ibf_a;
            group_b_input_full_r  <= b_strb && ibf_b;
            group_a_irq_request_r <= a_strb && inte_a && ibf_a;
            group_b_irq_request_r <= b_strb && inte_b && ibf_b;
            group_a_space_r       <= a_strb && rdy_a;
            group_b_space_r       <= b_strb && rdy_b;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            third_port_hi_o_r  <= 2'h0;
            third_port_hi_oe_r <= 1'b0;
        end
        else if (ce)
        begin
            third_port_hi_o_r  <= third_r[7:6];
            third_port_hi_oe_r <= !mode_r[`SIPP_BIT_A_UPIN];
        end
    end

    // ==========================================
    // Assertions
    property p_irq_a;
        @(posedge sys_clk) disable iff (srst)
        ce |=> group_a_irq_request_r == $past(a_strb && inte_a && ibf_a);
    endproperty
    a_irq_a: assert property (p_irq_a) else $error("group A request wrong");

    property p_full_a;
        @(posedge sys_clk) disable iff (srst)
        (ce && fall_a && rdy_a && !mode_wr) |=> ibf_a ##1 (!ce || group_a_input_full_r);
    endproperty
    a_full_a: assert property (p_full_a) else $error("group A capture lost");

    property p_full_b;
        @(posedge sys_clk) disable iff (srst)
        (ce && fall_b && rdy_b && !mode_wr) |=> ibf_b;
    endproperty
    a_full_b: assert property (p_full_b) else $error("group B capture lost");

    property p_pop_a;
        @(posedge sys_clk) disable iff (srst)
        (ce && pop_a && ibf_a && rdy_a && !fall_a) |=> !ibf_a;
    endproperty
    a_pop_a: assert property (p_pop_a) else $error("group A read kept full");

    property p_stat;
        @(posedge sys_clk) disable iff (srst)
        (ce && req.rd && req.addr == `SIPP_OFF_THIRD && a_strb && b_strb)
        |=> rd_data_r[5:0] == {$past(ibf_a), $past(inte_a), $past(inte_a && ibf_a),
                               $past(inte_b), $past(ibf_b), $past(inte_b && ibf_b)};
    endproperty
    a_stat: assert property (p_stat) else $error("status byte wrong");

    property p_no_strobe;
        @(posedge sys_clk) disable iff (srst)
        (ce && req.rd && req.addr == `SIPP_OFF_THIRD && b_strb && !link_b.strobe_n)
        |=> rd_data_r[0] == $past(inte_b && ibf_b);
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("strobe in status");

    property p_bsr;
        @(posedge sys_clk) disable iff (srst)
        (ce && bsr_wr) |=> third_r[$past(req.data[3:1])] == $past(req.data[0])
            && ((third_r ^ $past(third_r)) & ~$past(sel_mask)) == 8'h00;
    endproperty
    a_bsr: assert property (p_bsr) else $error("set/reset disturbed a bit");

    property p_mode;
        @(posedge sys_clk) disable iff (srst)
        (ce && mode_wr) |=> mode_r == $past(req.data) && third_r == 8'h00 && !ibf_a;
    endproperty
    a_mode: assert property (p_mode) else $error("mode word not taken");

    property p_rd_mode;
        @(posedge sys_clk) disable iff (srst)
        (ce && req.rd && req.addr == `SIPP_OFF_MODE) |=> rd_data_r == $past(mode_r);
    endproperty
    a_rd_mode: assert property (p_rd_mode) else $error("mode read wrong");

    property p_spare;
        @(posedge sys_clk) disable iff (srst)
        (ce && a_strb && !mode_r[`SIPP_BIT_A_UPIN]) |=> third_port_hi_oe_r
            && third_port_hi_o_r == $past(third_r[7:6]);
    endproperty
    a_spare: assert property (p_spare) else $error("spare lines not driven");

    c_cap_a: cover property (@(posedge sys_clk) disable iff (srst) ce && fall_a && rdy_a);
    c_full_a: cover property (@(posedge sys_clk) disable iff (srst) a_strb && !rdy_a);
    c_pop_a: cover property (@(posedge sys_clk) disable iff (srst) ce && pop_a && ibf_a);
    c_irq_b: cover property (@(posedge sys_clk) disable iff (srst) group_b_irq_request_r);
endmodule : sipp_top
`default_nettype wire

// ===== sipp_periph.sv
// Peripheral model that strobes bytes into one group of the port pair.
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// Strobing source
module sipp_periph (
    input  wire logic                 sys_clk,
    input  wire logic                 space,
    output var  sipp_pkg::sipp_link_s link
);
    import sipp_pkg::*;

    initial
    begin
        link = '{strobe_n: 1'b1, pins: 8'h00};
    end

    // Waits a random while and for room in the buffer, then strobes one byte.
    // Released pins show the inverse of the byte so that stale data cannot pass.
    task automatic send(input logic [7:0] d);
        int n;
        n = 0;
        repeat ($urandom_range(0, 3)) @(posedge sys_clk);
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (space !== 1'b1 && n < 50);
        link <= '{strobe_n: 1'b0, pins: d};
        repeat (2) @(posedge sys_clk);
        link <= '{strobe_n: 1'b1, pins: ~d};
    endtask : send
endmodule : sipp_periph
`default_nettype wire

// ===== strobed_input_port_pair_tb.sv
// Self-checking bench for the strobed input port pair.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) \
    begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end

module strobed_input_port_pair_tb;
    import sipp_pkg::*;
    localparam int LIMIT = 3000;
    logic        sys_clk;
    logic        srst;
    logic        ce;
    sipp_req_s   req;
    sipp_link_s  link_a;
    sipp_link_s  link_b;
    logic [7:0]  rd_data_r;
    logic        full_a;
    logic        full_b;
    logic        irq_a;
    logic        irq_b;
    logic        space_a;
    logic        space_b;
    logic [1:0]  hi_i;
    logic [1:0]  hi_o;
    logic        hi_oe;
    logic [7:0]  exp_q[$];
    logic [7:0]  exp_v;
    logic        rd_pend;
    logic [7:0]  d0, d1, d2, d3;
    int          bad_count;
    int          num_checks;
    int          cyc;

    sipp_top DUT (.sys_clk(sys_clk), .srst(srst), .ce(ce), .req(req), .rd_data_r(rd_data_r),
        .link_a(link_a), .link_b(link_b), .group_a_input_full_r(full_a),
        .group_b_input_full_r(full_b), .group_a_irq_request_r(irq_a),
        .group_b_irq_request_r(irq_b), .group_a_space_r(space_a), .group_b_space_r(space_b),
        .third_port_hi_i(hi_i), .third_port_hi_o_r(hi_o), .third_port_hi_oe_r(hi_oe));
    sipp_periph u_pa (.sys_clk(sys_clk), .space(space_a), .link(link_a));
    sipp_periph u_pb (.sys_clk(sys_clk), .space(space_b), .link(link_b));

    always #50 sys_clk = ~sys_clk;

    // ==========================================
    // Bus tasks and read monitor
    task automatic access(input logic w, input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= {w, ~w, a, d};
        @(posedge sys_clk);
        req <= '0;
    endtask : access

    task automatic rd(input logic [1:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        access(1'b0, a, 8'h00);
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic wait_full(input logic grp);
        int n;
        n = 0;
        while ((grp ? full_b : full_a) !== 1'b1 && n < 50)
        begin
            @(posedge sys_clk);
            n++;
        end
        #1;
    endtask : wait_full

    task complete_run;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : complete_run

    always @(posedge sys_clk)
    begin
        if (rd_pend)
        begin
            exp_v = exp_q.pop_front();
            `CHK("rd_data_r", exp_v, rd_data_r)
        end
        rd_pend <= req.rd;
        cyc++;
        if (cyc == LIMIT)
        begin
            bad_count++;
            complete_run();
        end
    end

    // ==========================================
    // Main sequence
    initial
    begin
        void'($urandom(32'h51473a40));
        sys_clk = 1'b0;
        srst = 1'b1;
        ce = 1'b1;
        req = '0;
        rd_pend = 1'b0;
        hi_i = 2'($urandom_range(1, 3));
        {d0, d1, d2, d3} = $urandom;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        settle();
        `CHK("full_a", 1'b0, full_a)
        `CHK("hi_oe", 1'b0, hi_oe)
        $display("test reset done");

        access(1'b1, 2'h3, 8'hb8);
        rd(2'h2, {hi_i, 6'h00});
        access(1'b1, 2'h3, 8'hb0);
        access(1'b1, 2'h3, 8'h0d);
        access(1'b1, 2'h3, 8'h09);
        settle();
        `CHK("hi_oe", 1'b1, hi_oe)
        `CHK("hi_o", 2'h1, hi_o)
        rd(2'h2, 8'h50);
        $display("test spare lines done");

        u_pa.send(d0);
        wait_full(1'b0);
        `CHK("irq_a", 1'b1, irq_a)
        rd(2'h2, 8'h78);
        rd(2'h0, d0);
        settle();
        `CHK("full_a", 1'b0, full_a)
        `CHK("irq_a", 1'b0, irq_a)
        $display("test group a capture done");

        access(1'b1, 2'h3, 8'h08);
        u_pa.send(d1);
        u_pa.send(d2);
        repeat (3) @(posedge sys_clk);
        #1;
        `CHK("space_a", 1'b0, space_a)
        `CHK("irq_a", 1'b0, irq_a)
        rd(2'h0, d1);
        settle();
        `CHK("full_a", 1'b1, full_a)
        rd(2'h0, d2);
        settle();
        `CHK("full_a", 1'b0, full_a)
        `CHK("space_a", 1'b1, space_a)
        $display("test buffer done");

        access(1'b1, 2'h3, 8'h86);
        access(1'b1, 2'h3, 8'h05);
        u_pb.send(d3);
        wait_full(1'b1);
        `CHK("irq_b", 1'b1, irq_b)
        rd(2'h2, 8'h07);
        rd(2'h1, d3);
        rd(2'h2, 8'h04);
        settle();
        `CHK("full_b", 1'b0, full_b)
        `CHK("irq_b", 1'b0, irq_b)
        $display("test group b capture done");

        ce <= 1'b0;
        access(1'b1, 2'h3, 8'h04);
        ce <= 1'b1;
        rd(2'h2, 8'h04);
        $display("test clock enable done");

        access(1'b1, 2'h3, 8'hb6);
        access(1'b1, 2'h3, 8'h09);
        fork
            u_pb.send(d1);
            begin
                @(negedge link_b.strobe_n);
                rd(2'h2, 8'h12);
            end
        join
        rd(2'h1, d1);
        rd(2'h3, 8'hb6);
        settle();
        `CHK("space_b", 1'b1, space_b)
        `CHK("full_b", 1'b0, full_b)
        $display("test both groups done");
        complete_run();
    end
endmodule : strobed_input_port_pair_tb
`default_nettype wire
